// ==== hdl/eac_pkg.sv ====
// Constants, types and register map of the EEPROM access controller
// ============================================================
// Overview of operation
// - Low data register, eight bits read/write, holds the byte moved, resets to zero.
// - Low address register, eight bits read/write, selects the byte, resets to zero.
// - High data register keeps bits 5..0; bits 7..6 always read zero.
// - High address register keeps bits 4..0; bits 7..5 always read zero.
// - Control bit 7 selects program space when one; bits 6..4 read zero.
// - Control bit 3 sets when a write is cut short by the pin, watchdog or brownout reset; power-on reset clears it.
// - Control bit 2 allows write cycles; zero blocks every data write.
// - Control bit 1 starts a write; software only sets, hardware clears at end.
// - Control bit 0 starts a read; software only sets, hardware clears it.
// - A triggered data read lands in the low data register next cycle.
// - Low data register holds the read value until next read or write.
// - Write starts only after 55h then AAh to unlock port, then write go.
// - Write go cannot be set unless write allow is already one.
// - Hardware never clears write allow; only software changes it.
// - A started write completes even if write allow is cleared meanwhile.
// - On completion write go clears and the write done flag sets.
// - Unlock port stores nothing, reads all zeros, serves the unlock only.
// - Write done flag lives in the second peripheral flag register.
// - Data memory holds 256 bytes, addresses 00h to FFh via low address.
// - A byte write erases the location first; an internal timer paces it.
package eac_pkg;

  // ============================================================
  // Register map
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFS_DATA_LOW = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_ADDR_LOW = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_DATA_HIGH = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_ADDR_HIGH = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_UNLOCK = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_PFLAGS2 = 3'h6;

  // ============================================================
  // Field layout
  localparam int CTL_SPACE = 7;
  localparam int CTL_ABORT = 3;
  localparam int CTL_ALLOW = 2;
  localparam int CTL_WGO = 1;
  localparam int CTL_RGO = 0;
  localparam int PF2_DONE = 4;
  localparam int DATA_HIGH_W = 6;
  localparam int ADDR_HIGH_W = 5;
  localparam int PGM_DATA_W = 14;
  localparam int PGM_ADDR_W = 13;
  localparam int MEM_DEPTH = 256;

  // ============================================================
  // Values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // ============================================================
  // Timing
  localparam int CLK_MHZ = 10;

  // ============================================================
  // Types
  typedef enum logic [1:0] {
    EAC_LOCKED,
    EAC_SAW_FIRST,
    EAC_ARMED
  } eac_unlock_t;

  typedef enum logic [1:0] {
    EAC_IDLE,
    EAC_ERASE,
    EAC_PROGRAM
  } eac_wstate_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eac_bus_req_t;

  typedef struct packed {
    logic ext_pin;
    logic watchdog;
    logic brownout;
  } eac_reset_src_t;

endpackage

// ==== hdl/eac_top.sv ====
// EEPROM access controller: register file, unlock, read path, timed byte write
`timescale 1ns/1ps
`default_nettype none
module eac_top #(
  parameter int WRITE_TIME_US = 4000,
  parameter int WRITE_CYCLES = WRITE_TIME_US * eac_pkg::CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Other reset sources, synchronous levels
  input wire eac_pkg::eac_reset_src_t reset_src,
  // Register port
  input wire eac_pkg::eac_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Program memory read port
  output logic [eac_pkg::PGM_ADDR_W-1:0] pgm_addr,
  input wire logic [eac_pkg::PGM_DATA_W-1:0] pgm_rdata,
  // Status
  output logic write_done_flag,
  output logic write_busy
);
  import eac_pkg::*;

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(WRITE_CYCLES / 2);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // ============================================================
  // Storage
  logic [7:0] mem_data_low_r;
  logic [DATA_HIGH_W-1:0] mem_data_high_r;
  logic [7:0] mem_addr_low_r;
  logic [ADDR_HIGH_W-1:0] mem_addr_high_r;
  logic space_select_r;
  logic write_abort_flag_r;
  logic write_allow_r;
  logic write_go_r;
  logic read_go_r;
  logic write_done_r;
  logic [7:0] rdata_r;
  logic [7:0] array_r [MEM_DEPTH];
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [CNT_W-1:0] cnt_r;
  eac_unlock_t unlock_r;
  eac_unlock_t unlock_nxt;
  eac_wstate_t wstate_r;

  // ============================================================
  // Decode
  function automatic logic hit(input eac_bus_req_t req, input logic [ADDR_W-1:0] ofs);
    hit = req.wr && (req.addr == ofs);
  endfunction

  logic reset_any;
  logic wr_data_low;
  logic wr_addr_low;
  logic wr_data_high;
  logic wr_addr_high;
  logic wr_control;
  logic wr_unlock;
  logic wr_pflags2;
  logic space_nxt;
  logic read_start;
  logic write_start;
  logic write_end;

  // Other reset sources also clear the block, but mark an interrupted write
  assign reset_any = rst | reset_src.ext_pin | reset_src.watchdog | reset_src.brownout;
  assign wr_data_low = hit(bus_req, OFS_DATA_LOW);
  assign wr_addr_low = hit(bus_req, OFS_ADDR_LOW);
  assign wr_data_high = hit(bus_req, OFS_DATA_HIGH);
  assign wr_addr_high = hit(bus_req, OFS_ADDR_HIGH);
  assign wr_control = hit(bus_req, OFS_CONTROL);
  assign wr_unlock = hit(bus_req, OFS_UNLOCK);
  assign wr_pflags2 = hit(bus_req, OFS_PFLAGS2);
  assign space_nxt = bus_req.wdata[CTL_SPACE];

  // Starts are ignored while a write runs
  assign read_start = wr_control && bus_req.wdata[CTL_RGO] && !write_go_r;
  // Allow is the value already held, not the one in this same write
  assign write_start = wr_control && bus_req.wdata[CTL_WGO] && !write_go_r
    && write_allow_r
    && (unlock_r == EAC_ARMED)
    && !space_nxt;
  assign write_end = (wstate_r == EAC_PROGRAM) && (cnt_r == CNT_LAST);

  // ============================================================
  // Unlock sequence
  // Any bus write other than the expected next step or a repeated 55h drops the sequence
  always_comb begin
    unlock_nxt = unlock_r;
    if (bus_req.wr) begin
      unique case (unlock_r)
        EAC_LOCKED: begin
          if (wr_unlock && bus_req.wdata == UNLOCK_FIRST) begin
            unlock_nxt = EAC_SAW_FIRST;
          end
        end
        EAC_SAW_FIRST: begin
          if (wr_unlock && bus_req.wdata == UNLOCK_SECOND) begin
            unlock_nxt = EAC_ARMED;
          end else if (wr_unlock && bus_req.wdata == UNLOCK_FIRST) begin
            unlock_nxt = EAC_SAW_FIRST;
          end else begin
            unlock_nxt = EAC_LOCKED;
          end
        end
        EAC_ARMED: begin
          // Consumed by the next bus write, whatever register it hits
          unlock_nxt = EAC_LOCKED;
        end
        default: begin
          unlock_nxt = EAC_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      unlock_r <= EAC_LOCKED;
    end else begin
      unlock_r <= unlock_nxt;
    end
  end

  // ============================================================
  // Address registers
  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      mem_addr_low_r <= BYTE_ZERO;
    end else if (wr_addr_low) begin
      mem_addr_low_r <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      mem_addr_high_r <= '0;
    end else if (wr_addr_high) begin
      mem_addr_high_r <= bus_req.wdata[ADDR_HIGH_W-1:0];
    end
  end

  assign pgm_addr = {mem_addr_high_r, mem_addr_low_r};

  // ============================================================
  // Data registers
  // Read data is loaded on the edge that takes the start, so the very
  // next bus read already sees it
  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      mem_data_low_r <= BYTE_ZERO;
    end else if (read_start && !space_nxt) begin
      mem_data_low_r <= array_r[mem_addr_low_r];
    end else if (read_start) begin
      mem_data_low_r <= pgm_rdata[7:0];
    end else if (wr_data_low) begin
      mem_data_low_r <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      mem_data_high_r <= '0;
    end else if (read_start && space_nxt) begin
      mem_data_high_r <= pgm_rdata[PGM_DATA_W-1:8];
    end else if (wr_data_high) begin
      mem_data_high_r <= bus_req.wdata[DATA_HIGH_W-1:0];
    end
  end

  // ============================================================
  // Control register
  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      space_select_r <= 1'b0;
    end else if (wr_control) begin
      space_select_r <= space_nxt;
    end
  end

  // Only software moves the allow bit, even mid write
  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      write_allow_r <= 1'b0;
    end else if (wr_control) begin
      write_allow_r <= bus_req.wdata[CTL_ALLOW];
    end
  end

  logic write_abort_flag_nxt;
  always_comb begin
    write_abort_flag_nxt = write_abort_flag_r;
    if (reset_any && write_go_r) begin
      write_abort_flag_nxt = 1'b1;
    end else if (!reset_any && wr_control) begin
      write_abort_flag_nxt = bus_req.wdata[CTL_ABORT];
    end
  end

  // Survives the other reset sources so software can retry the byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_abort_flag_r <= 1'b0;
    end else begin
      write_abort_flag_r <= write_abort_flag_nxt;
    end
  end

  // Software can set go bits, never clear them
  logic write_go_nxt;
  always_comb begin
    write_go_nxt = write_go_r;
    if (write_start) begin
      write_go_nxt = 1'b1;
    end else if (write_end) begin
      write_go_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      write_go_r <= 1'b0;
    end else begin
      write_go_r <= write_go_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      read_go_r <= 1'b0;
    end else begin
      read_go_r <= read_start;
    end
  end

  // ============================================================
  // Second peripheral flag register
  // A completion in the same cycle as a software clear keeps the flag set
  logic write_done_nxt;
  always_comb begin
    write_done_nxt = write_done_r;
    if (write_end) begin
      write_done_nxt = 1'b1;
    end else if (wr_pflags2) begin
      write_done_nxt = bus_req.wdata[PF2_DONE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      write_done_r <= 1'b0;
    end else begin
      write_done_r <= write_done_nxt;
    end
  end

  assign write_done_flag = write_done_r;
  assign write_busy = write_go_r;

  // ============================================================
  // Timed byte write
  // Address and data are latched so later register writes cannot
  // disturb the byte in flight
  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      wr_addr_r <= BYTE_ZERO;
    end else if (write_start) begin
      wr_addr_r <= mem_addr_low_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      wr_data_r <= BYTE_ZERO;
    end else if (write_start) begin
      wr_data_r <= mem_data_low_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_any) begin
      wstate_r <= EAC_IDLE;
      cnt_r <= CNT_ZERO;
    end else begin
      unique case (wstate_r)
        EAC_IDLE: begin
          cnt_r <= CNT_ZERO;
          if (write_start) begin
            wstate_r <= EAC_ERASE;
          end
        end
        EAC_ERASE: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_HALF) begin
            wstate_r <= EAC_PROGRAM;
          end
        end
        EAC_PROGRAM: begin
          // Allow is not looked at here, the cycle always runs out
          cnt_r <= cnt_r + 1'b1;
          if (write_end) begin
            wstate_r <= EAC_IDLE;
          end
        end
        default: begin
          wstate_r <= EAC_IDLE;
        end
      endcase
    end
  end

  // Only power-on reset erases the array; other resets keep contents,
  // but an interrupted byte may be left erased
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        array_r[i] <= BYTE_ERASED;
      end
    end else if (!reset_any && wstate_r == EAC_ERASE && cnt_r == CNT_HALF) begin
      array_r[wr_addr_r] <= BYTE_ERASED;
    end else if (!reset_any && write_end) begin
      array_r[wr_addr_r] <= wr_data_r;
    end
  end

  // ============================================================
  // Read back
  function automatic logic [7:0] ctl_view(input logic space, input logic abort,
      input logic allow, input logic wgo, input logic rgo);
    ctl_view = BYTE_ZERO;
    ctl_view[CTL_SPACE] = space;
    ctl_view[CTL_ABORT] = abort;
    ctl_view[CTL_ALLOW] = allow;
    ctl_view[CTL_WGO] = wgo;
    ctl_view[CTL_RGO] = rgo;
  endfunction

  logic [7:0] rmux;
  always_comb begin
    rmux = BYTE_ZERO;
    unique case (bus_req.addr)
      OFS_DATA_LOW: rmux = mem_data_low_r;
      OFS_ADDR_LOW: rmux = mem_addr_low_r;
      OFS_DATA_HIGH: rmux = {2'h0, mem_data_high_r};
      OFS_ADDR_HIGH: rmux = {3'h0, mem_addr_high_r};
      OFS_CONTROL: begin
        rmux = ctl_view(space_select_r, write_abort_flag_r, write_allow_r,
          write_go_r, read_go_r);
      end
      OFS_UNLOCK: rmux = BYTE_ZERO;
      OFS_PFLAGS2: rmux[PF2_DONE] = write_done_r;
      default: rmux = BYTE_ZERO;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = BYTE_ZERO;
    if (bus_req.rd) begin
      rdata_nxt = rmux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= BYTE_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata = rdata_r;

endmodule
`default_nettype wire

// ==== tb/eac_pgm_model.sv ====
// Program flash model for the access controller bench
`timescale 1ns/1ps
`default_nettype none
module eac_pgm_model (
  // Word address in, word out
  input wire logic [eac_pkg::PGM_ADDR_W-1:0] pgm_addr,
  output logic [eac_pkg::PGM_DATA_W-1:0] pgm_rdata
);
  import eac_pkg::*;
  // Pattern differs per address so a wrong address shows
  assign pgm_rdata = {pgm_addr, 1'b1} ^ 14'h2A5C;
endmodule
`default_nettype wire

// ==== tb/eac_top_checker.sv ====
// Port assertions for the EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module eac_top_checker #(
  parameter int WRITE_TIME_US = 4000,
  parameter int WRITE_CYCLES = 8
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire eac_pkg::eac_reset_src_t reset_src,
  // Register port
  input wire eac_pkg::eac_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  // Memory side and status
  input wire logic [eac_pkg::PGM_ADDR_W-1:0] pgm_addr,
  input wire logic [eac_pkg::PGM_DATA_W-1:0] pgm_rdata,
  input wire logic write_done_flag,
  input wire logic write_busy
);
  import eac_pkg::*;
  localparam int SLACK = 8;
  logic any_rst;
  logic rd_q;
  logic [ADDR_W-1:0] addr_q;
  assign any_rst = rst || reset_src != 3'b000;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (any_rst);
  // ====
  // Read tracking, so read data are tied to their address
  always_ff @(posedge clk_sys) begin
    rd_q <= bus_req.rd && !any_rst;
    addr_q <= bus_req.addr;
  end
  a_unlock_reads_zero: assert property (rd_q && addr_q == OFS_UNLOCK |-> bus_rdata == 8'h00)
    else $error("unlock port read not zero");
  a_ctl_unused_zero: assert property (rd_q && addr_q == OFS_CONTROL |-> bus_rdata[6:4] == 3'h0)
    else $error("control unused bits set");
  a_dhigh_unused: assert property (rd_q && addr_q == OFS_DATA_HIGH |-> bus_rdata[7:6] == 2'h0)
    else $error("data high unused bits set");
  a_ahigh_unused: assert property (rd_q && addr_q == OFS_ADDR_HIGH |-> bus_rdata[7:5] == 3'h0)
    else $error("addr high unused bits set");
  a_addr_low_load: assert property (bus_req.wr && bus_req.addr == OFS_ADDR_LOW |=>
    pgm_addr[7:0] == $past(bus_req.wdata)) else $error("low address not loaded");
  a_start_by_go: assert property ($rose(write_busy) |-> $past(bus_req.wr) &&
    $past(bus_req.addr) == OFS_CONTROL && $past(bus_req.wdata[CTL_WGO]))
    else $error("write began without write go");
  a_done_at_end: assert property ($fell(write_busy) && !$past(any_rst) |-> write_done_flag)
    else $error("done flag missing at write end");
  a_done_kept: assert property (write_done_flag &&
    !(bus_req.wr && bus_req.addr == OFS_PFLAGS2) |=> write_done_flag)
    else $error("done flag dropped by hardware");
  // Duration only bounded loosely: the exact count is a design choice
  a_write_timed: assert property ($rose(write_busy) |-> write_busy [*6] ##[0:SLACK] !write_busy)
    else $error("write time out of range");
  c_write_done: cover property ($fell(write_busy) && write_done_flag);
  c_abort: cover property (disable iff (rst) write_busy ##1 reset_src != 3'b000);
  c_pgm_read: cover property (rd_q && addr_q == OFS_DATA_HIGH && bus_rdata != 8'h00);
endmodule
bind eac_top eac_top_checker #(.WRITE_TIME_US(WRITE_TIME_US), .WRITE_CYCLES(WRITE_CYCLES)) chk (
  .clk_sys(clk_sys), .rst(rst), .reset_src(reset_src), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pgm_addr(pgm_addr), .pgm_rdata(pgm_rdata),
  .write_done_flag(write_done_flag), .write_busy(write_busy));
`default_nettype wire

// ==== tb/eac_top_test.sv ====
// Self-checking bench for the EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module eac_top_test;
  import eac_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  eac_reset_src_t reset_src = '0;
  eac_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic [PGM_ADDR_W-1:0] pgm_addr;
  logic [PGM_DATA_W-1:0] pgm_rdata;
  logic write_done_flag;
  logic write_busy;
  logic [7:0] exp_q[$];
  logic [7:0] ex_v;
  logic rd_q = 1'b0;
  logic [31:0] seed = 32'hE204C854;
  logic [7:0] a;
  logic [7:0] d;
  logic [13:0] w;
  logic [7:0] mask [4] = '{8'hFF, 8'hFF, 8'h3F, 8'h1F};
  int failures = 0;
  int check_count = 0;
  always #50 clk_sys = ~clk_sys;
  // Short write time keeps the run brief
  eac_top #(.WRITE_CYCLES(8)) dut (.clk_sys(clk_sys), .rst(rst), .reset_src(reset_src),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .pgm_addr(pgm_addr), .pgm_rdata(pgm_rdata),
    .write_done_flag(write_done_flag), .write_busy(write_busy));
  eac_pgm_model pgm (.pgm_addr(pgm_addr), .pgm_rdata(pgm_rdata));
  // ====
  // Bus tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic bus(input logic [2:0] ad, input logic [7:0] dt, input logic wi, input logic ri);
    bus_req <= '{addr: ad, wdata: dt, wr: wi, rd: ri};
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
    bus(ad, dt, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [2:0] ad, input logic [7:0] ex);
    exp_q.push_back(ex);
    bus(ad, 8'h00, 1'b0, 1'b1);
  endtask
  task automatic start_write(input logic [7:0] ad, input logic [7:0] dt);
    wr(OFS_ADDR_LOW, ad);
    wr(OFS_DATA_LOW, dt);
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    wr(OFS_CONTROL, 8'h06);
  endtask
  // Polls off the edge so the busy update has landed
  task automatic wait_idle();
    int n = 0;
    bus_req <= '0;
    while (n < 100 && write_busy !== 1'b0) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 100) failures++;
    @(posedge clk_sys);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ====
  // Result monitor: read data stand one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_q) begin
      ex_v = exp_q.pop_front();
      `CHK(bus_rdata, ex_v)
    end
    rd_q <= bus_req.rd;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    end_sim();
  end
  // ====
  // Scenarios
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      d = i == 0 ? 8'hFF : seed[7:0];
      for (int j = 0; j < 4; j++) begin
        wr(j[2:0], d);
        rd(j[2:0], d & mask[j]);
      end
      wr(OFS_UNLOCK, d);
      rd(OFS_UNLOCK, 8'h00);
    end
    // Same top byte twice: a missing erase would leave stale ones
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      a = i == 1 ? 8'h00 : 8'hFF;
      d = seed[15:8];
      start_write(a, d);
      wr(OFS_CONTROL, i == 0 ? 8'h05 : 8'h01);
      rd(OFS_CONTROL, i == 0 ? 8'h06 : 8'h02);
      `CHK(write_busy, 1'b1)
      wait_idle();
      `CHK(write_done_flag, 1'b1)
      rd(OFS_CONTROL, i == 0 ? 8'h04 : 8'h00);
      rd(OFS_DATA_LOW, d);
      rd(OFS_PFLAGS2, 8'h10);
      wr(OFS_PFLAGS2, 8'h00);
      rd(OFS_PFLAGS2, 8'h00);
      wr(OFS_DATA_LOW, 8'h00);
      wr(OFS_CONTROL, 8'h01);
      rd(OFS_DATA_LOW, d);
    end
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    wr(OFS_CONTROL, 8'h02);
    rd(OFS_CONTROL, 8'h00);
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_CONTROL, 8'h06);
    rd(OFS_CONTROL, 8'h04);
    seed = lfsr(seed);
    w = {seed[12:0], 1'b1} ^ 14'h2A5C;
    wr(OFS_ADDR_HIGH, {3'h0, seed[12:8]});
    wr(OFS_ADDR_LOW, seed[7:0]);
    wr(OFS_CONTROL, 8'h81);
    rd(OFS_DATA_LOW, w[7:0]);
    rd(OFS_DATA_HIGH, {2'h0, w[13:8]});
    rd(OFS_CONTROL, 8'h80);
    for (int k = 0; k < 3; k++) begin
      start_write(8'h10, 8'h5A);
      reset_src <= 3'b001 << k;
      bus(3'h0, 8'h00, 1'b0, 1'b0);
      reset_src <= 3'b000;
      rd(OFS_CONTROL, 8'h08);
      wr(OFS_CONTROL, 8'h00);
    end
    bus(3'h0, 8'h00, 1'b0, 1'b0);
    bus(3'h0, 8'h00, 1'b0, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
